/* File: blc_core.sv */
`default_nettype none
// Operation
// - Generate programmed dark row count each frame
// - Global shutter dark row: 240 kernels
// - Rolling shutter dark row: window line length
// - Skip bit blanks first dark row, unused
// - Auto mode computes, applies offset to image
// - Manual mode applies programmed offset and sign
// - Dark pixels leave uncorrected, raw; skipped row leaves as zeros
// - Manual offset same for every column
// - Offset all ones freezes auto corrections
// - Sign zero adds, one subtracts, manual
// - Auto corrections recomputed every frame
// - Separate correction per kernel column
// - Filter over 2^depth samples, flag shortage
module blc_core
	import blc_pkg::*;
#(
	parameter int PIX_W  = 10,
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	input  wire logic              frame_start,
	input  wire logic [15:0]       window_line_len,
	output logic                   dark_phase,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [PIX_W-1:0]  in_pixel,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic      [PIX_W-1:0]  out_pixel,
	output logic                   out_dark,
	output logic                   out_blank
);
	localparam int SUM_W  = PIX_W + 7;
	localparam int CORR_W = PIX_W + 2;
	localparam int NCOL   = BLC_KERNEL_COLS;

	if (PIX_W < 9 || PIX_W > 16 || ADDR_W < 12) begin : g_chk
		$error("blc_core: PIX_W must be 9..16 and ADDR_W at least 12");
	end

	function automatic logic blc_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		blc_hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
	endfunction : blc_hit

	// Sum is one bit wider than either operand, so the clamp sees the true sign
	function automatic logic [PIX_W-1:0] blc_apply(input logic [PIX_W-1:0] p,
		input logic signed [CORR_W-1:0] c);
		logic signed [CORR_W:0] s;
		s = $signed({2'b00, p}) + $signed({c[CORR_W-1], c});
		if (s < 0)
			blc_apply = '0;
		else if (s > $signed({2'b00, {PIX_W{1'b1}}}))
			blc_apply = '1;
		else
			blc_apply = s[PIX_W-1:0];
	endfunction : blc_apply

	logic [15:0]             ctrl_q;
	logic [15:0]             rows_q;
	logic [15:0]             filt_q;
	logic [15:0]             tgt_q;
	logic [31:0]             prdata_q;
	logic [NCOL-1:0]         short_q;
	blc_state_e              st_q;
	logic [7:0]              nrows_q;
	logic                    gate_q;
	logic [2:0]              dep_q;
	logic [15:0]             rowlen_q;
	logic [15:0]             pos_q;
	logic [7:0]              row_q;
	logic [2:0]              col_q;
	logic                    take;
	logic                    row_end;
	logic                    dark_end;
	logic                    use_row;
	logic                    auto_en;
	logic                    frozen;
	logic [7:0]              need;
	logic signed [CORR_W-1:0] man_corr;
	logic signed [CORR_W-1:0] man_mag;
	logic signed [CORR_W-1:0] corr_q [NCOL];
	logic signed [CORR_W-1:0] corr_use;
	logic                    buf_ready;
	logic [PIX_W+1:0]        buf_in;
	logic [PIX_W+1:0]        buf_out;
	logic [PIX_W-1:0]        pix_res;
	logic                    wr_en;
	logic                    setup;

	// APB: no wait states, error on unmapped word
	assign pready  = 1'b1;
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pwrite;
	assign pslverr = psel & penable & ~(blc_hit(paddr, BLC_IDX_FILTER) | blc_hit(paddr, BLC_IDX_CTRL) |
		blc_hit(paddr, BLC_IDX_STATUS) | blc_hit(paddr, BLC_IDX_TARGET) | blc_hit(paddr, BLC_IDX_ROWS));
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= BLC_CTRL_RST;
			rows_q <= BLC_ROWS_RST;
			filt_q <= BLC_FILTER_RST;
			tgt_q  <= BLC_TARGET_RST;
		end else if (wr_en) begin
			if (blc_hit(paddr, BLC_IDX_CTRL))
				ctrl_q <= {5'h00, pwdata[10:0]};
			if (blc_hit(paddr, BLC_IDX_ROWS))
				rows_q <= {7'h00, pwdata[8:0]};
			if (blc_hit(paddr, BLC_IDX_FILTER))
				filt_q <= {5'h00, pwdata[10:8], 8'h00};
			if (blc_hit(paddr, BLC_IDX_TARGET))
				tgt_q <= {5'h00, pwdata[10:0]};
		end
	end

	// Read data is latched in the setup cycle so it stands for the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			if (blc_hit(paddr, BLC_IDX_CTRL))
				prdata_q <= {16'h0000, ctrl_q};
			else if (blc_hit(paddr, BLC_IDX_ROWS))
				prdata_q <= {16'h0000, rows_q};
			else if (blc_hit(paddr, BLC_IDX_FILTER))
				prdata_q <= {16'h0000, filt_q};
			else if (blc_hit(paddr, BLC_IDX_TARGET))
				prdata_q <= {16'h0000, tgt_q};
			else if (blc_hit(paddr, BLC_IDX_STATUS))
				prdata_q <= {24'h00_0000, short_q};
			else
				prdata_q <= 32'h0000_0000;
		end
	end

	// Mode bits act at once; the frame geometry and the filter depth wait for frame_start
	assign auto_en  = ctrl_q[BLC_CTRL_AUTO_BIT];
	assign frozen   = (ctrl_q[BLC_CTRL_SIGN_BIT-1:BLC_CTRL_OFF_LSB] == BLC_FREEZE_CODE);
	// Nine-bit offset; PIX_W of nine or more leaves room for the sign
	assign man_mag  = signed'(CORR_W'({7'h00, ctrl_q[BLC_CTRL_SIGN_BIT-1:BLC_CTRL_OFF_LSB]}));
	assign man_corr = ctrl_q[BLC_CTRL_SIGN_BIT] ? -man_mag : man_mag;
	assign need     = 8'd1 << dep_q;

	assign take     = in_valid & in_ready;
	assign row_end  = take && (st_q == BLC_ST_DARK) && (pos_q == rowlen_q - 16'd1);
	assign dark_end = row_end && (row_q == nrows_q - 8'd1);
	assign use_row  = !(gate_q && row_q == 8'd0);
	assign dark_phase = (st_q == BLC_ST_DARK);

	// Frame settings are latched at frame start so a mid-frame write cannot tear a frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nrows_q  <= 8'h00;
			gate_q   <= 1'b0;
			dep_q    <= 3'h0;
			rowlen_q <= BLC_GS_ROW_PIX;
		end else if (frame_start) begin
			nrows_q <= rows_q[7:0];
			gate_q  <= rows_q[BLC_ROWS_GATE_BIT];
			dep_q   <= filt_q[BLC_FILT_LSB+2:BLC_FILT_LSB];
			if (tgt_q[BLC_TGT_ROLL_BIT])
				rowlen_q <= window_line_len;
			else
				rowlen_q <= BLC_GS_ROW_PIX;
		end
	end

	// A zero row count skips the dark phase; software must not program it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q  <= BLC_ST_IDLE;
			pos_q <= 16'h0000;
			row_q <= 8'h00;
			col_q <= 3'h0;
		end else if (frame_start) begin
			pos_q <= 16'h0000;
			row_q <= 8'h00;
			col_q <= 3'h0;
			st_q  <= (rows_q[7:0] != 8'h00) ? BLC_ST_DARK : BLC_ST_IMAGE;
		end else begin
			case (st_q)
				BLC_ST_IDLE: begin
					st_q <= BLC_ST_IDLE;
				end
				BLC_ST_DARK: begin
					if (take) begin
						col_q <= col_q + 3'd1;
						pos_q <= pos_q + 16'd1;
					end
					if (row_end) begin
						pos_q <= 16'h0000;
						col_q <= 3'h0;
						row_q <= row_q + 8'd1;
					end
					if (dark_end)
						st_q <= BLC_ST_IMAGE;
				end
				BLC_ST_IMAGE: begin
					if (take)
						col_q <= col_q + 3'd1;
				end
				default: begin
					st_q <= BLC_ST_IDLE;
				end
			endcase
		end
	end

	// One accumulator per kernel column; too few samples raises that column's flag
	for (genvar c = 0; c < NCOL; c++) begin : g_col
		logic [SUM_W-1:0] sum_q;
		logic [7:0]       cnt_q;
		logic [SUM_W-1:0] sum_nx;
		logic [7:0]       cnt_nx;
		logic [SUM_W-1:0] avg;

		always_comb begin
			sum_nx = sum_q;
			cnt_nx = cnt_q;
			if (take && st_q == BLC_ST_DARK && col_q == 3'(c) && use_row && cnt_q < need) begin
				sum_nx = sum_q + SUM_W'(in_pixel);
				cnt_nx = cnt_q + 8'd1;
			end
			avg = sum_nx >> dep_q;
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sum_q <= '0;
				cnt_q <= 8'h00;
			end else if (frame_start) begin
				sum_q <= '0;
				cnt_q <= 8'h00;
			end else begin
				sum_q <= sum_nx;
				cnt_q <= cnt_nx;
			end
		end

		// Shortage flag is rewritten every frame, so it needs no clear
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				corr_q[c]  <= '0;
				short_q[c] <= 1'b0;
			end else if (dark_end) begin
				short_q[c] <= (cnt_nx < need);
				if (auto_en && !frozen)
					corr_q[c] <= $signed({2'b00, tgt_q[PIX_W-1:0]}) - $signed({2'b00, avg[PIX_W-1:0]});
			end
		end
	end

	// Manual mode bypasses the stored factors but keeps them for auto
	assign corr_use = auto_en ? corr_q[col_q] : man_corr;
	assign pix_res  = blc_apply(in_pixel, corr_use);

	// Dark pixels pass raw; the skipped row leaves as zeros
	always_comb begin
		if (st_q == BLC_ST_DARK && !use_row)
			buf_in = {1'b1, 1'b1, {PIX_W{1'b0}}};
		else if (st_q == BLC_ST_DARK)
			buf_in = {1'b1, 1'b0, in_pixel};
		else if (st_q == BLC_ST_IMAGE)
			buf_in = {1'b0, 1'b0, pix_res};
		else
			buf_in = {1'b0, 1'b0, in_pixel};
	end

	// Buffer absorbs a receiver stall; its ready stalls the pixel source
	assign in_ready = buf_ready;

	blc_buf2 #(
		.W(PIX_W + 2)
	) u_buf (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_valid (in_valid),
		.in_ready (buf_ready),
		.in_data  (buf_in),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data (buf_out)
	);

	assign out_dark  = buf_out[PIX_W+1];
	assign out_blank = buf_out[PIX_W];
	assign out_pixel = buf_out[PIX_W-1:0];
endmodule : blc_core
`default_nettype wire

/* File: blc_pkg.sv */
`default_nettype none
package blc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  BLC_IDX_FILTER     = 10'h080;
	localparam logic [9:0]  BLC_IDX_CTRL       = 10'h081;
	localparam logic [9:0]  BLC_IDX_STATUS     = 10'h088;
	localparam logic [9:0]  BLC_IDX_TARGET     = 10'h08c;
	localparam logic [9:0]  BLC_IDX_ROWS       = 10'h0c5;

	// Field positions
	localparam int          BLC_CTRL_AUTO_BIT  = 0;
	localparam int          BLC_CTRL_OFF_LSB   = 1;
	localparam int          BLC_CTRL_SIGN_BIT  = 10;
	localparam int          BLC_ROWS_GATE_BIT  = 8;
	localparam int          BLC_FILT_LSB       = 8;
	localparam int          BLC_TGT_ROLL_BIT   = 10;

	// Values after reset
	localparam logic [15:0] BLC_CTRL_RST       = 16'h0001;
	localparam logic [15:0] BLC_ROWS_RST       = 16'h0001;
	localparam logic [15:0] BLC_FILTER_RST     = 16'h0000;
	localparam logic [15:0] BLC_TARGET_RST     = 16'h0000;

	// Offset pattern that freezes automatic correction
	localparam logic [8:0]  BLC_FREEZE_CODE    = 9'h1ff;

	// Dark row geometry in global shutter operation
	localparam int          BLC_KERNEL_COLS    = 8;
	localparam logic [15:0] BLC_GS_KERNELS     = 16'h00f0;
	localparam logic [15:0] BLC_GS_ROW_PIX     = 16'h0780;

	typedef enum logic [1:0] {
		BLC_ST_IDLE,
		BLC_ST_DARK,
		BLC_ST_IMAGE
	} blc_state_e;
endpackage : blc_pkg
`default_nettype wire

/* File: blc_buf2.sv */
`default_nettype none
module blc_buf2 #(
	parameter int W = 12
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	if (W < 1) begin : g_chk
		$error("blc_buf2: W must be positive");
	end

	logic [W-1:0] mem_q [2];
	logic         wp_q;
	logic         rp_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push)
				wp_q <= ~wp_q;
			if (pop)
				rp_q <= ~rp_q;
			if (push && !pop)
				cnt_q <= cnt_q + 2'd1;
			else if (pop && !push)
				cnt_q <= cnt_q - 2'd1;
		end
	end
endmodule : blc_buf2
`default_nettype wire

/* File: blc_core_monitor.sv */
`default_nettype none
module blc_core_monitor #(
	parameter int PIX_W = 10
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic             pready,
	input wire logic [31:0]      prdata,
	input wire logic             pslverr,
	input wire logic             frame_start,
	input wire logic             dark_phase,
	input wire logic             in_valid,
	input wire logic             in_ready,
	input wire logic             out_valid,
	input wire logic             out_ready,
	input wire logic [PIX_W-1:0] out_pixel,
	input wire logic             out_dark,
	input wire logic             out_blank
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take; in_valid && in_ready; endsequence
	sequence s_stall; out_valid && !out_ready; endsequence
	property p_start; frame_start |=> dark_phase; endproperty
	a_start: assert property (p_start) else $error("dark rows did not start");
	property p_src; $rose(dark_phase) |-> $past(frame_start); endproperty
	a_src: assert property (p_src) else $error("dark phase without frame start");
	property p_first; s_take ##0 !out_valid |=> out_valid; endproperty
	a_first: assert property (p_first) else $error("output late");
	property p_hold; s_stall |=> out_valid && $stable({out_pixel, out_dark, out_blank}); endproperty
	a_hold: assert property (p_hold) else $error("output changed while stalled");
	property p_blank; out_valid && out_blank |-> out_dark && out_pixel == '0; endproperty
	a_blank: assert property (p_blank) else $error("blanked pixel not zero");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state inserted");
	property p_prd; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_prd: assert property (p_prd) else $error("read data moved");
endmodule : blc_core_monitor
`default_nettype wire

/* File: blc_core_bench.sv */
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module blc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slv;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        frame_start = 0, dark_phase, in_valid = 0, in_ready, out_valid, out_ready = 0;
	logic [9:0]  in_pixel = '0, out_pixel;
	logic        out_dark, out_blank;
	logic [11:0] q[$];
	int          err_count = 0, cmp_count = 0;
	blc_core blc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.frame_start(frame_start), .window_line_len(16'h0010), .dark_phase(dark_phase), .in_valid(in_valid),
		.in_ready(in_ready), .in_pixel(in_pixel), .out_valid(out_valid), .out_ready(out_ready),
		.out_pixel(out_pixel), .out_dark(out_dark), .out_blank(out_blank));
	always #2 pclk = ~pclk;
	// Receiver stalls every other cycle so the buffer fills
	always @(posedge pclk) begin
		out_ready <= ~out_ready;
		if (out_valid && out_ready) q.push_back({out_dark, out_blank, out_pixel});
	end
	task stop_test;
		$display("Checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, '0);
		`CHK("prdata", e, r)
	endtask : rd
	task px(input logic [9:0] v);
		in_valid <= 1;
		in_pixel <= v;
		do @(posedge pclk); while (in_ready !== 1'b1);
	endtask : px
	// Dark value and image result step per kernel column
	task frame(input int nd, nb, input logic [9:0] dv, ds, iv, ev, ck);
		int i, k;
		logic [11:0] e;
		q.delete();
		@(posedge pclk) frame_start <= 1;
		@(posedge pclk) frame_start <= 0;
		for (i = 0; i < nd + 16; i++) px(i < nd ? 10'(dv + (i % 8) * ds) : iv);
		in_valid <= 0;
		for (k = 0; k < 50 && q.size() < nd + 16; k++) @(posedge pclk);
		`CHK("count", nd + 16, q.size())
		for (i = 0; i < q.size(); i++) begin
			e = i < nb ? 12'hc00 : i < nd ? {2'b10, 10'(dv + (i % 8) * ds)} : {2'b00, 10'(ev - (i % 8) * ck)};
			`CHK("pixel", e, q[i])
		end
		$display("Frame of %0d dark pixels done", nd);
	endtask : frame
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rd(12'h204, 32'h1);
		rd(12'h314, 32'h1);
		rd(12'h3fc, 32'h0);
		`CHK("pslverr", 1'b1, slv)
		apb(1, 12'h204, 32'hffff);
		rd(12'h204, 32'h7ff);
		$display("Register test done");
		apb(1, 12'h204, 32'h0a);
		frame(1920, 0, 10'h040, 10'h1, 10'h100, 10'h105, 10'h0);
		apb(1, 12'h230, 32'h400);
		apb(1, 12'h314, 32'h103);
		apb(1, 12'h204, 32'h440);
		frame(48, 16, 10'h050, 10'h1, 10'h010, 10'h000, 10'h0);
		apb(1, 12'h314, 32'h001);
		apb(1, 12'h204, 32'h3fe);
		frame(16, 0, 10'h000, 10'h0, 10'h300, 10'h3ff, 10'h0);
		apb(1, 12'h230, 32'h440);
		apb(1, 12'h204, 32'h401);
		frame(16, 0, 10'h030, 10'h1, 10'h100, 10'h110, 10'h1);
		frame(16, 0, 10'h020, 10'h2, 10'h100, 10'h120, 10'h2);
		apb(1, 12'h204, 32'h3ff);
		apb(1, 12'h200, 32'h300);
		frame(16, 0, 10'h000, 10'h0, 10'h100, 10'h120, 10'h2);
		rd(12'h220, 32'hff);
		stop_test();
	end
	// Whole run needs about 4400 cycles
	initial begin
		repeat (40000) @(posedge pclk);
		err_count++;
		stop_test();
	end
endmodule : blc_core_bench
bind blc_core blc_core_monitor #(.PIX_W(PIX_W)) blc_core_monitor_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.frame_start(frame_start), .dark_phase(dark_phase), .in_valid(in_valid), .in_ready(in_ready),
	.out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel), .out_dark(out_dark),
	.out_blank(out_blank));
`default_nettype wire
